// file: vtps_pkg.sv
`default_nettype none
package vtps_pkg;
  // register offsets
  localparam logic [7:0] VTPS_LOOP_PWR_OFS = 8'h63;
  localparam logic [7:0] VTPS_CTRL_OFS = 8'h64;
  localparam logic [7:0] VTPS_CFG_OFS = 8'h65;
  localparam logic [7:0] VTPS_RED_OFS = 8'h70;
  localparam logic [7:0] VTPS_GREEN_OFS = 8'h71;
  localparam logic [7:0] VTPS_BLUE_OFS = 8'h72;
  localparam logic [7:0] VTPS_FRAMES_OFS = 8'h73;
  localparam logic [7:0] VTPS_STATUS_OFS = 8'h74;
  // reset values
  localparam logic [7:0] VTPS_CTRL_RST = 8'h10;
  localparam logic [7:0] VTPS_LOOP_PWR_RST = 8'h00;
  localparam logic [7:0] VTPS_FRAMES_RST = 8'h01;
  // control and config field positions
  localparam int VTPS_EN_BIT = 0;
  localparam int VTPS_REV_BIT = 1;
  localparam int VTPS_BARS_BIT = 2;
  localparam int VTPS_COMPL_BIT = 3;
  localparam int VTPS_SEL_LSB = 4;
  localparam int VTPS_ADV_BIT = 0;
  localparam int VTPS_INV_BIT = 1;
  // fixed pattern codes
  localparam logic [3:0] VTPS_P_WHITE = 4'h1;
  localparam logic [3:0] VTPS_P_BLACK = 4'h2;
  localparam logic [3:0] VTPS_P_RED = 4'h3;
  localparam logic [3:0] VTPS_P_GREEN = 4'h4;
  localparam logic [3:0] VTPS_P_BLUE = 4'h5;
  localparam logic [3:0] VTPS_P_HRAMP_W = 4'h6;
  localparam logic [3:0] VTPS_P_HRAMP_B = 4'h8;
  localparam logic [3:0] VTPS_P_VRAMP_W = 4'h9;
  localparam logic [3:0] VTPS_P_VRAMP_B = 4'hc;
  localparam logic [3:0] VTPS_P_BANDS = 4'hd;
  localparam logic [3:0] VTPS_P_CUSTOM = 4'he;
  localparam logic [3:0] VTPS_P_FIRST = 4'h1;
  localparam logic [3:0] VTPS_P_LAST = 4'he;
  // source of the pattern on the output, for status
  typedef enum logic [1:0] {
    VTPS_SRC_OFF = 2'b00,
    VTPS_SRC_FIXED = 2'b01,
    VTPS_SRC_BARS = 2'b10,
    VTPS_SRC_COMPL = 2'b11
  } vtps_src_t;
endpackage : vtps_pkg
`default_nettype wire

// file: vtps_pix_if.sv
`default_nettype none
// pixel position and colour between top and the colour engine
interface vtps_pix_if #(parameter int HW = 11, parameter int VW = 11);
  logic [HW-1:0] h_pos;
  logic [VW-1:0] v_pos;
  logic [HW-1:0] h_active;
  logic [VW-1:0] v_active;
  logic [3:0] code;
  logic [1:0] src;
  logic invert;
  logic band_rev;
  logic [23:0] custom_rgb;
  logic [23:0] rgb;
  modport ctl (output h_pos, v_pos, h_active, v_active, code, src, invert, band_rev, custom_rgb, input rgb);
  modport eng (input h_pos, v_pos, h_active, v_active, code, src, invert, band_rev, custom_rgb, output rgb);
endinterface : vtps_pix_if
`default_nettype wire

// file: vtps_colour.sv
`default_nettype none
// combinational colour engine: one pixel colour from position and selection
module vtps_colour
  import vtps_pkg::*;
(
  vtps_pix_if.eng pix
);
  logic [7:0] hr;
  logic [7:0] vr;
  logic [23:0] base;
  logic [2:0] bar;
  logic [1:0] band;
  logic [31:0] hprod;
  logic [31:0] vprod;

  // ramp levels spread evenly over the active extent
  always_comb begin
    hprod = 32'(pix.h_pos) * 32'd256;
    vprod = 32'(pix.v_pos) * 32'd256;
    hr = 8'(hprod / 32'(pix.h_active == '0 ? 1 : pix.h_active));
    vr = 8'(vprod / 32'(pix.v_active == '0 ? 1 : pix.v_active));
    bar = 3'(hprod / 32'(pix.h_active == '0 ? 1 : pix.h_active) >> 5);
    band = 2'(vprod / 32'(pix.v_active == '0 ? 1 : pix.v_active) >> 6);
  end

  // base colour before inversion; priority decided in top via src
  always_comb begin
    base = 24'h000000;
    if (pix.src == VTPS_SRC_COMPL) begin
      // compliance pattern: checkerboard of 8x8 pixel cells
      base = (pix.h_pos[3] ^ pix.v_pos[3]) ? 24'hffffff : 24'h000000;
    end else if (pix.src == VTPS_SRC_BARS) begin
      case (bar)
        3'd0: base = 24'hffffff;
        3'd1: base = 24'hffff00;
        3'd2: base = 24'h00ffff;
        3'd3: base = 24'h00ff00;
        3'd4: base = 24'hff00ff;
        3'd5: base = 24'hff0000;
        3'd6: base = 24'h0000ff;
        default: base = 24'h000000;
      endcase
    end else if (pix.src == VTPS_SRC_FIXED) begin
      case (pix.code)
        4'h1: base = 24'hffffff;
        4'h2: base = 24'h000000;
        4'h3: base = 24'hff0000;
        4'h4: base = 24'h00ff00;
        4'h5: base = 24'h0000ff;
        4'h6: base = {hr, hr, hr};
        4'h7: base = {hr, 8'h00, 8'h00};
        4'h8: base = {8'h00, hr, 8'h00};
        4'h9: base = {vr, vr, vr};
        4'ha: base = {vr, 8'h00, 8'h00};
        4'hb: base = {8'h00, vr, 8'h00};
        4'hc: base = {8'h00, 8'h00, vr};
        4'hd: begin
          // four bands from the top; reverse bit swaps yellow and blue
          case (band)
            2'd0: base = pix.band_rev ? 24'h0000ff : 24'hffff00;
            2'd1: base = 24'h00ffff;
            2'd2: base = pix.band_rev ? 24'hffff00 : 24'h0000ff;
            default: base = 24'hff0000;
          endcase
        end
        4'he: base = pix.custom_rgb;
        default: base = 24'h000000; // reserved codes give black
      endcase
    end
  end

  // inversion gives the complementary colour; off and reserved stay black
  always_comb begin
    if (pix.src == VTPS_SRC_OFF || (pix.src == VTPS_SRC_FIXED && (pix.code == 4'h0 || pix.code == 4'hf)))
      pix.rgb = 24'h000000;
    else
      pix.rgb = pix.invert ? ~base : base;
  end
endmodule : vtps_colour
`default_nettype wire

// file: vtps_top.sv
`default_nettype none
// Operation
// - fixed codes 1, 2, 3 give white, black, red; 0 and 15 reserved.
// - each code other than 0 and 15 gives a colour, or its complement when inverted; 0 and 15 stay black.
// - codes 6, 7, 8 are horizontal ramps to white, red, green.
// - ramp steps spread evenly across active width or height.
// - code 14 outputs custom colour from three channel registers.
// - auto-advance ignores the fixed selection field.
// - auto-advance moves to next pattern after programmed frame count.
// - compliance bit set selects compliance pattern, ignoring the field.
// - colour bar bit gives eight bars white to black.
// - band reverse bit swaps yellow and blue in four-band pattern.
// - enable bit turns generator on; resets off.
// - loop driver powered while its bit is 0; bit resets 0.
// - pattern control register at 64h resets to 10h.
// - a config bit chooses inverted colour variants.
module vtps_top
  import vtps_pkg::*;
#(
  parameter int HW = 11,
  parameter int VW = 11,
  parameter logic [10:0] H_ACTIVE = 11'd1920,
  parameter logic [10:0] V_ACTIVE = 11'd1080
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic pix_valid,
  input wire logic frame_start,
  output logic [23:0] pix_rgb,
  output logic pix_out_valid,
  output logic gen_active,
  output logic loop_driver_power_down
);
  typedef struct packed {
    logic [7:0] loop_pwr;
    logic [7:0] ctrl;
    logic [1:0] cfg;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic [7:0] frames;
    logic [7:0] frame_cnt;
    logic [3:0] auto_code;
    logic [HW-1:0] h_pos;
    logic [VW-1:0] v_pos;
    logic [7:0] rdata;
    logic [23:0] rgb;
    logic ovalid;
  } vtps_state_t;

  vtps_state_t st_reg;
  vtps_state_t st_next;
  logic [3:0] code_now;
  vtps_src_t src_now;
  logic gen_on;

  vtps_pix_if #(.HW(HW), .VW(VW)) pix ();

  vtps_colour vtps_colour_i (
    .pix(pix)
  );

  // pattern source by fixed priority
  always_comb begin
    gen_on = st_reg.ctrl[VTPS_EN_BIT];
    code_now = st_reg.cfg[VTPS_ADV_BIT] ? st_reg.auto_code : st_reg.ctrl[7:VTPS_SEL_LSB];
    if (!gen_on)
      src_now = VTPS_SRC_OFF;
    else if (st_reg.ctrl[VTPS_COMPL_BIT])
      src_now = VTPS_SRC_COMPL;
    else if (st_reg.ctrl[VTPS_BARS_BIT])
      src_now = VTPS_SRC_BARS;
    else
      src_now = VTPS_SRC_FIXED;
  end

  assign pix.h_pos = st_reg.h_pos;
  assign pix.v_pos = st_reg.v_pos;
  assign pix.h_active = HW'(H_ACTIVE);
  assign pix.v_active = VW'(V_ACTIVE);
  assign pix.code = code_now;
  assign pix.src = src_now;
  assign pix.invert = st_reg.cfg[VTPS_INV_BIT];
  assign pix.band_rev = st_reg.ctrl[VTPS_REV_BIT];
  assign pix.custom_rgb = {st_reg.red, st_reg.green, st_reg.blue};

  // next state: registers, raster position, auto-advance and read data
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;
    if (wr_stb) begin
      case (addr)
        VTPS_LOOP_PWR_OFS: st_next.loop_pwr = {7'h00, wdata[0]};
        VTPS_CTRL_OFS: st_next.ctrl = wdata;
        VTPS_CFG_OFS: st_next.cfg = wdata[1:0];
        VTPS_RED_OFS: st_next.red = wdata;
        VTPS_GREEN_OFS: st_next.green = wdata;
        VTPS_BLUE_OFS: st_next.blue = wdata;
        VTPS_FRAMES_OFS: st_next.frames = wdata;
        default: ;
      endcase
    end
    if (rd_stb) begin
      case (addr)
        VTPS_LOOP_PWR_OFS: st_next.rdata = st_reg.loop_pwr;
        VTPS_CTRL_OFS: st_next.rdata = st_reg.ctrl;
        VTPS_CFG_OFS: st_next.rdata = {6'h00, st_reg.cfg};
        VTPS_RED_OFS: st_next.rdata = st_reg.red;
        VTPS_GREEN_OFS: st_next.rdata = st_reg.green;
        VTPS_BLUE_OFS: st_next.rdata = st_reg.blue;
        VTPS_FRAMES_OFS: st_next.rdata = st_reg.frames;
        VTPS_STATUS_OFS: st_next.rdata = {1'b0, src_now, gen_on, code_now};
        default: st_next.rdata = 8'h00;
      endcase
    end
    // raster counters restart on each frame start
    if (frame_start) begin
      st_next.h_pos = '0;
      st_next.v_pos = '0;
    end else if (pix_valid) begin
      if (st_reg.h_pos == HW'(H_ACTIVE - 11'd1)) begin
        st_next.h_pos = '0;
        st_next.v_pos = (st_reg.v_pos == VW'(V_ACTIVE - 11'd1)) ? '0 : st_reg.v_pos + VW'(1);
      end else begin
        st_next.h_pos = st_reg.h_pos + HW'(1);
      end
    end
    // auto-advance counts frames only while on and generator enabled; when off, count clears and code follows the field, with 0 and 15 taken as code 1
    if (!st_reg.cfg[VTPS_ADV_BIT]) begin
      st_next.frame_cnt = 8'h00;
      st_next.auto_code = st_reg.ctrl[7:VTPS_SEL_LSB] == 4'h0 || st_reg.ctrl[7:VTPS_SEL_LSB] == 4'hf ?
        VTPS_P_FIRST : st_reg.ctrl[7:VTPS_SEL_LSB];
    end else if (frame_start && gen_on) begin
      if (st_reg.frame_cnt + 8'h01 >= st_reg.frames) begin
        st_next.frame_cnt = 8'h00;
        st_next.auto_code = (st_reg.auto_code == VTPS_P_LAST) ? VTPS_P_FIRST : st_reg.auto_code + 4'h1;
      end else begin
        st_next.frame_cnt = st_reg.frame_cnt + 8'h01;
      end
    end
    // pixel output registered one cycle after its position
    st_next.rgb = pix.rgb;
    st_next.ovalid = pix_valid && gen_on;
  end

  // state register; ctrl reset value selects code 1 with all bits cleared
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.ctrl <= VTPS_CTRL_RST;
      st_reg.loop_pwr <= VTPS_LOOP_PWR_RST;
      st_reg.frames <= VTPS_FRAMES_RST;
      st_reg.auto_code <= VTPS_P_FIRST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign pix_rgb = st_reg.rgb;
  assign pix_out_valid = st_reg.ovalid;
  assign gen_active = st_reg.ctrl[VTPS_EN_BIT];
  // loop driver power-down follows its bit; software sets it before enabling
  assign loop_driver_power_down = st_reg.loop_pwr[0];

  ctrl_reset_a: assert property (@(posedge clk) $rose(reset_n) |-> st_reg.ctrl == 8'h10)
    else $error("control register not at reset value");
  enable_off_a: assert property (@(posedge clk) disable iff (!reset_n) !gen_on |-> src_now == VTPS_SRC_OFF)
    else $error("source active while disabled");
  compl_prio_a: assert property (@(posedge clk) disable iff (!reset_n)
    gen_on && st_reg.ctrl[3] |-> src_now == VTPS_SRC_COMPL)
    else $error("compliance not selected");
  bars_prio_a: assert property (@(posedge clk) disable iff (!reset_n)
    gen_on && !st_reg.ctrl[3] && st_reg.ctrl[2] |-> src_now == VTPS_SRC_BARS)
    else $error("colour bars lost priority");
  driver_pwr_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_stb && addr == 8'h63 |=> loop_driver_power_down == $past(wdata[0]))
    else $error("driver power-down not following write");
  auto_ignore_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.cfg[0] |-> code_now == st_reg.auto_code)
    else $error("fixed field used in auto-advance");
  auto_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.cfg[0] && !frame_start && !wr_stb |=> $stable(st_reg.auto_code))
    else $error("auto code moved without frame");
  reserved_black_a: assert property (@(posedge clk) disable iff (!reset_n)
    src_now == VTPS_SRC_FIXED && code_now == 4'hf |=> pix_rgb == 24'h000000)
    else $error("reserved code not black");
  white_code_a: assert property (@(posedge clk) disable iff (!reset_n)
    src_now == VTPS_SRC_FIXED && code_now == 4'h1 && !st_reg.cfg[1] |=> pix_rgb == 24'hffffff)
    else $error("white code wrong");
  invert_a: assert property (@(posedge clk) disable iff (!reset_n)
    src_now == VTPS_SRC_FIXED && code_now == 4'h4 && st_reg.cfg[1] |=> pix_rgb == 24'hff00ff)
    else $error("inverted green not magenta");
endmodule : vtps_top
`default_nettype wire

// file: video_test_pattern_select_tb.sv
`default_nettype none
module video_test_pattern_select_tb
  import vtps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic pix_valid = 1'b0;
  logic frame_start = 1'b0;
  logic [7:0] rdata;
  logic [23:0] pix_rgb;
  logic pix_out_valid;
  logic gen_active;
  logic loop_driver_power_down;
  logic [23:0] px [0:127];
  logic pov;
  logic [7:0] rv;
  logic [7:0] rv2;
  int num_errors = 0;
  int checked = 0;
  // solid colours by code 0..5, colour bars left to right
  localparam logic [23:0] FIX [0:5] = '{24'h000000, 24'hffffff, 24'h000000, 24'hff0000, 24'h00ff00, 24'h0000ff};
  localparam logic [23:0] BAR [0:7] = '{24'hffffff, 24'hffff00, 24'h00ffff, 24'h00ff00,
                                        24'hff00ff, 24'hff0000, 24'h0000ff, 24'h000000};

  // 20 ns clock
  always #10 clk = ~clk;

  // small raster keeps frames short: 16 x 8 pixels
  vtps_top #(.H_ACTIVE(11'd16), .V_ACTIVE(11'd8)) vtps_top_i (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pix_valid(pix_valid),
    .frame_start(frame_start), .pix_rgb(pix_rgb), .pix_out_valid(pix_out_valid), .gen_active(gen_active),
    .loop_driver_power_down(loop_driver_power_down));

  task automatic end_sim();
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // strobe lowered at the next edge; the wait lets the register update settle before any check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr

  // read data only stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, rv);
    chk({16'h0000, rv}, {16'h0000, exp});
  endtask : rchk

  // one frame start, then n pixels in raster order; colour lands a cycle later
  task automatic frame(input int n);
    pov = 1'b0;
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    pix_valid <= 1'b1;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      if (k == n - 1) pix_valid <= 1'b0;
      #1;
      px[k] = pix_rgb;
      pov = pov | pix_out_valid;
    end
  endtask : frame

  task automatic t_reset();
    rchk(VTPS_CTRL_OFS, 8'h10);
    rchk(VTPS_LOOP_PWR_OFS, 8'h00);
    rchk(8'h80, 8'h00);
    chk({22'h0, gen_active, loop_driver_power_down}, 24'h0);
    frame(1);
    chk({pov, px[0]}, 25'h0);
  endtask : t_reset

  task automatic t_power();
    wr(VTPS_LOOP_PWR_OFS, 8'h01);
    chk({23'h0, loop_driver_power_down}, 24'h1);
    rchk(VTPS_LOOP_PWR_OFS, 8'h01);
    wr(VTPS_CTRL_OFS, 8'h11);
    chk({23'h0, gen_active}, 24'h1);
    frame(1);
    chk({pov, px[0]}, {1'b1, 24'hffffff});
  endtask : t_power

  // solid codes plain and inverted, reserved codes black
  task automatic t_fixed();
    for (int inv = 0; inv < 2; inv++) begin
      wr(VTPS_CFG_OFS, inv[0] ? 8'h02 : 8'h00);
      for (int c = 1; c < 6; c++) begin
        wr(VTPS_CTRL_OFS, {c[3:0], 4'h1});
        frame(1);
        chk(px[0], inv[0] ? ~FIX[c] : FIX[c]);
      end
    end
    wr(VTPS_CFG_OFS, 8'h00);
    wr(VTPS_CTRL_OFS, 8'h01);
    frame(1);
    chk(px[0], 24'h000000);
    wr(VTPS_CTRL_OFS, 8'hf1);
    frame(1);
    chk(px[0], 24'h000000);
  endtask : t_fixed

  task automatic t_custom();
    wr(VTPS_RED_OFS, 8'h12);
    wr(VTPS_GREEN_OFS, 8'h34);
    wr(VTPS_BLUE_OFS, 8'h56);
    wr(VTPS_CTRL_OFS, 8'he1);
    frame(1);
    chk(px[0], 24'h123456);
    wr(VTPS_CFG_OFS, 8'h02);
    frame(1);
    chk(px[0], 24'hedcba9);
  endtask : t_custom

  // inverted ramps are complemented first, so one set of checks serves both
  task automatic t_ramp();
    logic [23:0] msk;
    logic [23:0] q0;
    logic [23:0] q8;
    logic [23:0] q15;
    for (int inv = 0; inv < 2; inv++) begin
      wr(VTPS_CFG_OFS, inv[0] ? 8'h02 : 8'h00);
      for (int c = 6; c < 9; c++) begin
        msk = (c == 6) ? 24'hffffff : (c == 7) ? 24'hff0000 : 24'h00ff00;
        wr(VTPS_CTRL_OFS, {c[3:0], 4'h1});
        frame(16);
        q0 = inv[0] ? ~px[0] : px[0];
        q8 = inv[0] ? ~px[8] : px[8];
        q15 = inv[0] ? ~px[15] : px[15];
        if (c == 8) begin
          q8 = q8 >> 8;
          q15 = q15 >> 8;
        end else begin
          q8 = q8 >> 16;
          q15 = q15 >> 16;
        end
        chk(q0, 24'h0);
        chk((inv[0] ? ~px[15] : px[15]) & ~msk, 24'h0);
        chk({23'h0, q15[7:0] >= 8'he0 && q8[7:0] >= 8'h70 && q8[7:0] <= 8'h90}, 24'h1);
      end
    end
    wr(VTPS_CFG_OFS, 8'h00);
    // vertical white ramp over 8 rows: 256 levels spread evenly, 32 per row
    wr(VTPS_CTRL_OFS, 8'h91);
    frame(128);
    chk(px[0], 24'h000000);
    chk(px[64], 24'h808080);
    chk(px[112], 24'he0e0e0);
  endtask : t_ramp

  // bars over 16 pixels are two pixels wide; compliance wins over bars
  task automatic t_bars();
    wr(VTPS_CTRL_OFS, 8'h15);
    frame(16);
    for (int i = 0; i < 8; i++) chk(px[2 * i], BAR[i]);
    rchk(VTPS_STATUS_OFS, 8'h51);
    wr(VTPS_CTRL_OFS, 8'h1d);
    frame(16);
    rchk(VTPS_STATUS_OFS, 8'h71);
    chk({23'h0, px[0] === ~px[8] && (px[0] === 24'h0 || px[0] === 24'hffffff)}, 24'h1);
  endtask : t_bars

  task automatic t_bands();
    for (int r = 0; r < 2; r++) begin
      wr(VTPS_CTRL_OFS, {4'hd, 2'b00, r[0], 1'b1});
      frame(128);
      chk(px[0], r[0] ? 24'h0000ff : 24'hffff00);
      chk(px[32], 24'h00ffff);
      chk(px[64], r[0] ? 24'hffff00 : 24'h0000ff);
      chk(px[96], 24'hff0000);
    end
  endtask : t_bands

  task automatic t_auto();
    wr(VTPS_FRAMES_OFS, 8'h01);
    wr(VTPS_CTRL_OFS, 8'h31);
    frame(1);
    frame(1);
    rchk(VTPS_STATUS_OFS, 8'h33);
    wr(VTPS_CFG_OFS, 8'h01);
    rd(VTPS_STATUS_OFS, rv2);
    frame(1);
    rd(VTPS_STATUS_OFS, rv);
    chk({23'h0, rv[3:0] !== rv2[3:0]}, 24'h1);
    rv2 = rv;
    wr(VTPS_CTRL_OFS, (rv[3:0] == 4'h5) ? 8'h61 : 8'h51);
    rchk(VTPS_STATUS_OFS, rv2);
    wr(VTPS_CFG_OFS, 8'h00);
  endtask : t_auto

  task automatic t_off();
    wr(VTPS_CTRL_OFS, 8'h10);
    chk({23'h0, gen_active}, 24'h0);
    frame(1);
    chk({pov, px[0]}, 25'h0);
  endtask : t_off

  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_power();
    t_fixed();
    t_custom();
    t_ramp();
    t_bars();
    t_bands();
    t_auto();
    t_off();
    end_sim();
  end

  // all scenarios need well under 5000 cycles
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule : video_test_pattern_select_tb
`default_nettype wire
